// File: design/pbo_pkg.sv
package pbo_pkg;
  // ------------------------------------------------------------
  // pin positions within the port
  // ------------------------------------------------------------
  localparam int unsigned PIN_CNT = 8;
  localparam int unsigned POS_SCK = 7;
  localparam int unsigned POS_MISO = 6;
  localparam int unsigned POS_MOSI = 5;
  localparam int unsigned POS_SS = 4;
  localparam int unsigned POS_CMPA = 3;
  localparam int unsigned POS_IRQ2 = 2;
  localparam int unsigned POS_DIVIDED_CLOCK_OUT = 1;
  localparam int unsigned POS_XCK = 0;

  // ------------------------------------------------------------
  // values after reset and counts of cycles
  // ------------------------------------------------------------
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic BIT_RST = 1'h0;
  // half period of the divided clock output, in mclk cycles
  localparam int unsigned DIVIDED_CLOCK_OUT_HALF_CYC = 1;
  localparam logic [7:0] DIVIDED_CLOCK_OUT_CNT_RST = 8'h00;
endpackage : pbo_pkg

// File: design/pbo_port_override.sv
// Operation
// - slave spi forces clock pin input
// - master spi forces data-in pin input
// - slave spi forces data-out pin input
// - slave spi forces select pin input
// - slave active only while select low
// - forced spi inputs keep port pull-up
// - spi data pins carry driving side value
// - compare b drives pin 4 when output
// - compare a drives pin 3 when output
// - fuse forces divided clock on pin 1
// - usart sync clock on pin 0
// - pin change mask forces input enable
// - irq2 or pin change enables pin 2
// - pins 1 and 0 feed timer counts
// - override enables select override values
// - input enable override beats sleep state
`timescale 1ns/1ps
`default_nettype none
module pbo_port_override
  import pbo_pkg::*;
#(
  parameter int unsigned DIVIDED_CLOCK_OUT_HALF = DIVIDED_CLOCK_OUT_HALF_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pullup_en,
  output logic [7:0] din_en,
  input wire logic [7:0] dir_bits,
  input wire logic [7:0] out_bits,
  input wire logic global_pullup_disable,
  input wire logic sleep_active,
  input wire logic spi_enable_flag,
  input wire logic spi_master_select,
  input wire logic spi_sck_out,
  input wire logic spi_slave_out,
  input wire logic spi_master_out,
  input wire logic timer0_compare_a_out,
  input wire logic timer0_compare_a_en,
  input wire logic timer0_compare_b_out,
  input wire logic timer0_compare_b_en,
  input wire logic clock_out_fuse,
  input wire logic usart0_sync_mode,
  input wire logic usart0_sync_clock_out,
  input wire logic ext_irq2_enable,
  input wire logic pin_change_group1_enable,
  input wire logic [7:0] pin_change_mask,
  output logic spi_sck_in,
  output logic spi_master_in,
  output logic spi_slave_in,
  output logic spi_select_in,
  output logic spi_slave_active,
  output logic ext_irq2_in,
  output logic [7:0] pin_change_in,
  output logic timer0_ext_count_in,
  output logic timer1_ext_count_in,
  output logic usart0_sync_clock_in,
  output logic divided_clock_out
);

  // ------------------------------------------------------------
  // override signal generation
  // ------------------------------------------------------------
  logic spi_slv;
  logic spi_mst;
  logic [7:0] pullup_override_en;
  logic [7:0] puov;
  logic [7:0] dir_override_en;
  logic [7:0] ddov;
  logic [7:0] value_override_en;
  logic [7:0] pvov;
  logic [7:0] input_enable_override_en;
  logic [7:0] input_enable_override_val;
  logic divided_clock_out_ff;

  assign spi_slv = spi_enable_flag & ~spi_master_select;
  assign spi_mst = spi_enable_flag & spi_master_select;

  // per-pin override enables and values
  always_comb begin
    pullup_override_en = 8'h00;
    puov = 8'h00;
    dir_override_en = 8'h00;
    ddov = 8'h00;
    value_override_en = 8'h00;
    pvov = 8'h00;
    input_enable_override_en = pin_change_mask & {PIN_CNT{pin_change_group1_enable}};
    input_enable_override_val = 8'hFF;
    dir_override_en[POS_SCK] = spi_slv;
    dir_override_en[POS_MISO] = spi_mst;
    dir_override_en[POS_MOSI] = spi_slv;
    dir_override_en[POS_SS] = spi_slv;
    pullup_override_en = dir_override_en;
    puov = out_bits & {PIN_CNT{~global_pullup_disable}};
    value_override_en[POS_SCK] = spi_mst;
    pvov[POS_SCK] = spi_sck_out;
    value_override_en[POS_MISO] = spi_slv;
    pvov[POS_MISO] = spi_slave_out;
    value_override_en[POS_MOSI] = spi_mst;
    pvov[POS_MOSI] = spi_master_out;
    value_override_en[POS_SS] = timer0_compare_b_en;
    pvov[POS_SS] = timer0_compare_b_out;
    value_override_en[POS_CMPA] = timer0_compare_a_en;
    pvov[POS_CMPA] = timer0_compare_a_out;
    input_enable_override_en[POS_IRQ2] = ext_irq2_enable | input_enable_override_en[POS_IRQ2];
    dir_override_en[POS_DIVIDED_CLOCK_OUT] = clock_out_fuse;
    ddov[POS_DIVIDED_CLOCK_OUT] = clock_out_fuse;
    value_override_en[POS_DIVIDED_CLOCK_OUT] = clock_out_fuse;
    pvov[POS_DIVIDED_CLOCK_OUT] = divided_clock_out_ff;
    // sync clock driven when direction set
    value_override_en[POS_XCK] = usart0_sync_mode & dir_bits[POS_XCK];
    pvov[POS_XCK] = usart0_sync_clock_out;
  end

  // ------------------------------------------------------------
  // pad drive
  // ------------------------------------------------------------
  logic [7:0] oe_ff;
  logic [7:0] out_ff;
  logic [7:0] pu_ff;
  logic [7:0] nxt_oe;
  logic [7:0] nxt_out;
  logic [7:0] nxt_pu;

  // final driver, value and pull-up selection
  always_comb begin
    nxt_oe = (dir_override_en & ddov) | (~dir_override_en & dir_bits);
    nxt_out = (value_override_en & pvov) | (~value_override_en & out_bits);
    nxt_pu = (pullup_override_en & puov)
           | (~pullup_override_en & out_bits & ~dir_bits & {PIN_CNT{~global_pullup_disable}});
    // a pin that drives never pulls up
    nxt_pu = nxt_pu & ~nxt_oe;
  end

  // pad flops sit on power-on reset so the clock output runs in reset
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      oe_ff <= PIN_RST;
      out_ff <= PIN_RST;
      pu_ff <= PIN_RST;
    end else begin
      oe_ff <= nxt_oe;
      out_ff <= nxt_out;
      pu_ff <= nxt_pu;
    end
  end

  assign pad_oe = oe_ff;
  assign pad_out = out_ff;
  assign pullup_en = pu_ff;

  // ------------------------------------------------------------
  // divided clock output
  // ------------------------------------------------------------
  logic [7:0] divided_clock_out_cnt_ff;
  logic [7:0] nxt_divided_clock_out_cnt;
  logic nxt_divided_clock_out;

  // divider toggles every DIVIDED_CLOCK_OUT_HALF cycles
  always_comb begin
    nxt_divided_clock_out_cnt = divided_clock_out_cnt_ff + 8'h01;
    nxt_divided_clock_out = divided_clock_out_ff;
    if (divided_clock_out_cnt_ff >= 8'(DIVIDED_CLOCK_OUT_HALF - 1)) begin
      nxt_divided_clock_out_cnt = DIVIDED_CLOCK_OUT_CNT_RST;
      nxt_divided_clock_out = ~divided_clock_out_ff;
    end
  end

  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      divided_clock_out_cnt_ff <= DIVIDED_CLOCK_OUT_CNT_RST;
      divided_clock_out_ff <= BIT_RST;
    end else begin
      divided_clock_out_cnt_ff <= nxt_divided_clock_out_cnt;
      divided_clock_out_ff <= nxt_divided_clock_out;
    end
  end

  assign divided_clock_out = divided_clock_out_ff;

  // ------------------------------------------------------------
  // digital input path
  // ------------------------------------------------------------
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] di_ff;
  logic [7:0] die_ff;
  logic act_ff;
  logic [7:0] nxt_die;
  logic [7:0] nxt_di;
  logic nxt_act;

  // input enable, gated input and slave activity
  always_comb begin
    nxt_die = (input_enable_override_en & input_enable_override_val) | (~input_enable_override_en & {PIN_CNT{~sleep_active}});
    nxt_di = sync2_ff & nxt_die;
    nxt_act = spi_slv & ~nxt_di[POS_SS];
  end

  // two-stage synchroniser and gated input flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= PIN_RST;
      sync2_ff <= PIN_RST;
      di_ff <= PIN_RST;
      die_ff <= PIN_RST;
      act_ff <= BIT_RST;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
      di_ff <= nxt_di;
      die_ff <= nxt_die;
      act_ff <= nxt_act;
    end
  end

  assign din_en = die_ff;
  assign pin_change_in = di_ff;
  assign spi_sck_in = di_ff[POS_SCK];
  assign spi_master_in = di_ff[POS_MISO];
  assign spi_slave_in = di_ff[POS_MOSI];
  assign spi_select_in = di_ff[POS_SS];
  assign spi_slave_active = act_ff;
  assign ext_irq2_in = di_ff[POS_IRQ2];
  assign timer1_ext_count_in = di_ff[POS_DIVIDED_CLOCK_OUT];
  assign timer0_ext_count_in = di_ff[POS_XCK];
  assign usart0_sync_clock_in = di_ff[POS_XCK];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_sck_slave_in: assert property (@(posedge mclk) disable iff (!resetn)
    spi_slv |=> !pad_oe[POS_SCK])
    else $error("clock pin drives in slave role");

  a_miso_master_in: assert property (@(posedge mclk) disable iff (!resetn)
    spi_mst |=> !pad_oe[POS_MISO])
    else $error("data-in pin drives in master role");

  a_mosi_slave_in: assert property (@(posedge mclk) disable iff (!resetn)
    spi_slv |=> !pad_oe[POS_MOSI])
    else $error("data-out pin drives in slave role");

  a_ss_slave_in: assert property (@(posedge mclk) disable iff (!resetn)
    spi_slv ##1 spi_slv |=> !pad_oe[POS_SS])
    else $error("select pin drives in slave role");

  a_slave_active_cause: assert property (@(posedge mclk) disable iff (!resetn)
    spi_slave_active |-> $past(spi_slv) && !spi_select_in)
    else $error("slave active without low select");

  a_spi_pullup_kept: assert property (@(posedge mclk) disable iff (!resetn)
    spi_slv && out_bits[POS_SCK] && !global_pullup_disable |=> pullup_en[POS_SCK])
    else $error("forced input lost its pull-up");

  a_mosi_master_val: assert property (@(posedge mclk) disable iff (!resetn)
    spi_mst && dir_bits[POS_MOSI] |=> pad_oe[POS_MOSI]
      && pad_out[POS_MOSI] == $past(spi_master_out))
    else $error("master output not on data-out pin");

  a_cmpb_drive: assert property (@(posedge mclk) disable iff (!resetn)
    timer0_compare_b_en && dir_bits[POS_SS] && !spi_slv
      |=> pad_oe[POS_SS] && pad_out[POS_SS] == $past(timer0_compare_b_out))
    else $error("compare b not on pin 4");

  a_cmpa_drive: assert property (@(posedge mclk) disable iff (!resetn)
    timer0_compare_a_en |=> pad_out[POS_CMPA] == $past(timer0_compare_a_out))
    else $error("compare a not on pin 3");

  a_divided_clock_out_forced: assert property (@(posedge mclk) disable iff (!por_n)
    clock_out_fuse |=> pad_oe[POS_DIVIDED_CLOCK_OUT] && pad_out[POS_DIVIDED_CLOCK_OUT] == $past(divided_clock_out_ff))
    else $error("divided clock not on pin 1");

  a_xck_drive: assert property (@(posedge mclk) disable iff (!resetn)
    usart0_sync_mode && dir_bits[POS_XCK]
      |=> pad_oe[POS_XCK] && pad_out[POS_XCK] == $past(usart0_sync_clock_out))
    else $error("sync clock not driven on pin 0");

  a_pc_input_en: assert property (@(posedge mclk) disable iff (!resetn)
    pin_change_group1_enable && pin_change_mask[POS_SCK] |=> din_en[POS_SCK])
    else $error("pin change input not enabled");

  a_irq2_input_en: assert property (@(posedge mclk) disable iff (!resetn)
    ext_irq2_enable |=> din_en[POS_IRQ2])
    else $error("irq2 input not enabled");

  a_sleep_gating: assert property (@(posedge mclk) disable iff (!resetn)
    sleep_active && !pin_change_group1_enable && !ext_irq2_enable |=> din_en == 8'h00)
    else $error("input enabled in sleep without override");

  a_plain_port: assert property (@(posedge mclk) disable iff (!resetn)
    !spi_enable_flag && !clock_out_fuse |=> pad_oe == $past(dir_bits))
    else $error("direction not from port bits");

endmodule : pbo_port_override
`default_nettype wire

// File: tb/pbo_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbo_pin_model (
  input wire logic mclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad_in
);
  logic flt_ff = 1'h0;
  // a floating pin wanders each cycle instead of holding its last level
  always @(posedge mclk) begin
    flt_ff <= ~flt_ff;
  end
  // pin level: device driver, then far side, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pullup_en[i] | flt_ff;
    end
  end
endmodule : pbo_pin_model
`default_nettype wire

// File: tb/tb_port_b_alternate_function_override.sv
`timescale 1ns/1ps
`default_nettype none
module tb_port_b_alternate_function_override;
  logic mclk = 1'b0;
  logic resetn, por_n, global_pullup_disable, sleep_active, spi_enable_flag, spi_master_select;
  logic spi_sck_out, spi_slave_out, spi_master_out, timer0_compare_a_out, timer0_compare_a_en;
  logic timer0_compare_b_out, timer0_compare_b_en, clock_out_fuse, usart0_sync_mode;
  logic usart0_sync_clock_out, ext_irq2_enable, pin_change_group1_enable, b;
  logic [7:0] dir_bits, out_bits, pin_change_mask, ext_val, ext_en;
  logic [7:0] pad_in, pad_out, pad_oe, pullup_en, din_en, pin_change_in;
  logic spi_sck_in, spi_master_in, spi_slave_in, spi_select_in, spi_slave_active;
  logic ext_irq2_in, timer0_ext_count_in, timer1_ext_count_in, usart0_sync_clock_in;
  logic divided_clock_out;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  // --------------------------------------------------------------
  // device and pins
  // --------------------------------------------------------------
  pbo_port_override #(.DIVIDED_CLOCK_OUT_HALF(2)) dut (.mclk, .resetn, .por_n, .pad_in, .pad_out, .pad_oe,
    .pullup_en, .din_en, .dir_bits, .out_bits, .global_pullup_disable, .sleep_active,
    .spi_enable_flag, .spi_master_select, .spi_sck_out, .spi_slave_out, .spi_master_out,
    .timer0_compare_a_out, .timer0_compare_a_en, .timer0_compare_b_out, .timer0_compare_b_en,
    .clock_out_fuse, .usart0_sync_mode, .usart0_sync_clock_out, .ext_irq2_enable,
    .pin_change_group1_enable, .pin_change_mask, .spi_sck_in, .spi_master_in, .spi_slave_in,
    .spi_select_in, .spi_slave_active, .ext_irq2_in, .pin_change_in, .timer0_ext_count_in,
    .timer1_ext_count_in, .usart0_sync_clock_in, .divided_clock_out);
  pbo_pin_model pins (.mclk, .pad_out, .pad_oe, .pullup_en, .ext_val, .ext_en, .pad_in);
  // clock and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      give_verdict();
    end
  end
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {resetn, por_n, global_pullup_disable, sleep_active, spi_enable_flag, spi_master_select} = '0;
    {spi_sck_out, spi_slave_out, spi_master_out, timer0_compare_a_out, timer0_compare_a_en} = '0;
    {timer0_compare_b_out, timer0_compare_b_en, clock_out_fuse, usart0_sync_mode} = '0;
    {usart0_sync_clock_out, ext_irq2_enable, pin_change_group1_enable, b} = '0;
    {dir_bits, out_bits, pin_change_mask, ext_val, ext_en} = '0;
    step(3);
    {por_n, resetn} = 2'h3;
    // plain port bits
    dir_bits = 8'hF0;
    out_bits = 8'hAA;
    step(1);
    chk(pad_oe, 8'hF0);
    chk(pad_out & pad_oe, 8'hA0);
    chk(pullup_en, 8'h0A);
    global_pullup_disable = 1'h1;
    step(1);
    chk(pullup_en, 8'h00);
    // spi slave role
    {global_pullup_disable, spi_enable_flag, spi_slave_out} = 3'h3;
    {dir_bits, out_bits} = 16'hFFFF;
    step(1);
    chk(pad_oe, 8'h4F);
    chk(pullup_en, 8'hB0);
    chk(pad_out & pad_oe, 8'h4F);
    spi_slave_out = 1'h0;
    ext_en = 8'h10;
    // the far master pulls select low
    step(3);
    chk(pad_out & pad_oe, 8'h0F);
    chk({spi_select_in, spi_slave_active, 6'h00}, 8'h40);
    ext_val = 8'h10;
    step(3);
    chk({spi_select_in, spi_slave_active, 6'h00}, 8'h80);
    // spi master role
    {spi_master_select, spi_sck_out, spi_master_out, ext_en} = 11'h700;
    out_bits = 8'h40;
    step(1);
    chk(pad_oe, 8'hBF);
    chk(pad_out & pad_oe, 8'hA0);
    chk(pullup_en, 8'h40);
    // timer compare outputs and usart sync clock
    {spi_enable_flag, timer0_compare_a_out, timer0_compare_a_en} = 3'h3;
    {timer0_compare_b_out, timer0_compare_b_en, dir_bits, out_bits} = 18'h31800;
    step(1);
    chk(pad_out & pad_oe, 8'h18);
    dir_bits = 8'h01;
    {usart0_sync_mode, usart0_sync_clock_out} = 2'h3;
    step(1);
    chk(pad_oe, 8'h01);
    chk(pad_out & pad_oe, 8'h01);
    usart0_sync_mode = 1'h0;
    step(1);
    chk(pad_out & pad_oe, 8'h00);
    // input enables in sleep
    {sleep_active, dir_bits} = 9'h100;
    step(1);
    chk(din_en, 8'h00);
    {pin_change_group1_enable, pin_change_mask} = 9'h10F;
    step(1);
    chk(din_en, 8'h0F);
    {pin_change_group1_enable, pin_change_mask, ext_irq2_enable} = 10'h001;
    step(1);
    chk(din_en, 8'h04);
    // inputs routed to peripherals
    {sleep_active, ext_irq2_enable, ext_en, ext_val} = 18'h0FFA6;
    step(3);
    chk(pin_change_in, 8'hA6);
    chk({5'h00, ext_irq2_in, timer1_ext_count_in, timer0_ext_count_in}, 8'h06);
    chk({spi_sck_in, spi_master_in, spi_slave_in, spi_select_in, 4'h0}, 8'hA0);
    ext_val = 8'h59;
    step(3);
    chk(pin_change_in, 8'h59);
    chk({6'h00, usart0_sync_clock_in, timer0_ext_count_in}, 8'h03);
    chk({spi_sck_in, spi_master_in, spi_slave_in, spi_select_in, 4'h0}, 8'h50);
    // divided clock, kept up through system reset
    {clock_out_fuse, ext_en} = 9'h100;
    step(1);
    chk(pad_oe, 8'h02);
    resetn = 1'h0;
    b = divided_clock_out;
    step(2);
    chk({7'h00, divided_clock_out}, {7'h00, ~b});
    b = divided_clock_out;
    step(1);
    chk({7'h00, pad_out[1]}, {7'h00, b});
    chk(pad_oe, 8'h02);
    give_verdict();
  end
endmodule : tb_port_b_alternate_function_override
`default_nettype wire
